// ### inc/mst_pkg.sv
// Purpose: Shared constants and types of the module sideband controller
// Assumes: clk_i at 125 MHz
// Notes: 2-wire byte map and Wishbone register map live here
package mst_pkg;
  // Clock rate and derived cycle counts
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned RST_MIN_US = 2;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned INIT_TIME_MS = 2000;
  localparam int unsigned INIT_CYC = INIT_TIME_MS * CLK_KHZ;
  localparam int unsigned INIT_W = 28;
  localparam int unsigned RST_CNT_W = 9;

  // Flag and event vector layout
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned FLG_LOS = 0;
  localparam int unsigned FLG_TXF = 1;
  localparam int unsigned FLG_OTH = 2;
  localparam int unsigned FLG_RDY = 3;
  localparam int unsigned EVT_RDY = 0;
  localparam int unsigned EVT_RST = 1;
  localparam int unsigned EVT_FRD = 2;
  localparam int unsigned EVT_CWR = 3;

  // Synchroniser vector layout
  localparam int unsigned SY_W = 8;
  localparam int unsigned SY_SCL = 7;
  localparam int unsigned SY_SDA = 6;
  localparam int unsigned SY_RST = 5;
  localparam int unsigned SY_SEL = 4;
  localparam int unsigned SY_LPR = 3;
  localparam int unsigned SY_LOS = 2;
  localparam int unsigned SY_TXF = 1;
  localparam int unsigned SY_OTH = 0;

  // 2-wire slave address and byte map
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] BYTE_STATUS = 8'h02;
  localparam logic [7:0] BYTE_FLAGS = 8'h03;
  localparam logic [7:0] BYTE_CTRL = 8'h5D;
  localparam logic [7:0] BYTE_MASK = 8'h64;
  localparam int unsigned STAT_DNR_BIT = 0;
  localparam int unsigned CTRL_PDOWN_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Wishbone byte offsets
  localparam logic [7:0] WB_STAT = 8'h00;
  localparam logic [7:0] WB_MASK = 8'h04;
  localparam logic [7:0] WB_STATE = 8'h08;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_WDATA = 3'h3,
    ST_WACK = 3'h4,
    ST_RDATA = 3'h5,
    ST_RACK = 3'h6
  } mst_i2c_e;
endpackage

// ### inc/mst_irq_if.sv
// Purpose: Carrier between the controller and a flag/mask unit
// Assumes: one clock domain
// Notes: set wins over clear inside the unit
`timescale 1ns/1ps
interface mst_irq_if;
  logic [mst_pkg::IRQ_W-1:0] set;
  logic [mst_pkg::IRQ_W-1:0] clr;
  logic [mst_pkg::IRQ_W-1:0] mask;
  logic [mst_pkg::IRQ_W-1:0] flags;
  logic irq;
  modport core(input set, input clr, input mask, output flags, output irq);
  modport user(output set, output clr, output mask, input flags, input irq);
endinterface

// ### hdl/mst_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: inputs are independent levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module mst_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [mst_pkg::SY_W-1:0] async_i,
  input wire logic [mst_pkg::SY_W-1:0] rst_val_i,
  output logic [mst_pkg::SY_W-1:0] sync_o
);
  logic [mst_pkg::SY_W-1:0] meta_ff;
  logic [mst_pkg::SY_W-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    meta_ff <= async_i;
    // Synchronous reset: idle levels come from a tie-off, not a flop reset value
    if (rst_i) begin
      sync_ff <= rst_val_i;
    end else begin
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// ### hdl/mst_irq.sv
// Purpose: Sticky flags, mask gating and registered interrupt level
// Assumes: set and clr are one-cycle pulses
// Notes: a set arriving with its clear keeps the flag
`timescale 1ns/1ps
module mst_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  mst_irq_if.core bus
);
  logic [mst_pkg::IRQ_W-1:0] flags_ff;
  logic [mst_pkg::IRQ_W-1:0] nxt_flags;
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    nxt_flags = (flags_ff & ~bus.clr) | bus.set;
    nxt_irq = |(flags_ff & ~bus.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
    end
  end

  assign bus.flags = flags_ff;
  assign bus.irq = irq_ff;
endmodule

// ### hdl/mst_sideband.sv
// Purpose: Sideband control of a pluggable transceiver module
// Assumes: pins are asynchronous; 2-wire clock well below clk_i
// Notes: 2-wire slave sampled, not clocked, by SCL
//
// Behaviour
// - Module is fully functional within 2000 ms of power-on, plug or reset release.
// - Reset pin low longer than 2 us is a reset; shorter pulses are ignored.
// - Module answers the 2-wire bus within 2000 ms of power-on.
// - Within 2000 ms data-not-ready clears and the interrupt asserts.
// - Fully functional within 2000 ms after reset pin rises.
// - Low-power request high enters lower power within 100 us.
// - Interrupt output goes low within 200 ms of a triggering condition.
// - Flags clear on read; interrupt releases within 500 us after that read.
// - Receive loss sets its flag and interrupt within 100 ms.
// - Any other condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit blocks that flag's interrupt within 100 ms.
// - Clearing a mask bit restores that flag's interrupt within 100 ms.
// - Module answers the 2-wire bus within 100 us of select assertion.
// - Module stops answering within 100 us of select deassertion.
// - Setting power-down override enters lower power within 100 ms.
// - Clearing power-down override returns to full function within 300 ms.
`timescale 1ns/1ps
module mst_sideband #(
  parameter int unsigned INIT_CYCLES = mst_pkg::INIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_irq_o,
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic rx_los_i,
  input wire logic tx_fault_i,
  input wire logic other_flag_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic interrupt_n_o,
  output logic module_present_n_o,
  output logic low_power_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history
  logic [mst_pkg::SY_W-1:0] s;
  logic [mst_pkg::SY_W-1:0] prev_ff;
  logic [mst_pkg::SY_W-1:0] nxt_prev;
  logic [mst_pkg::SY_W-1:0] idle_lvl;

  // Idle levels: bus lines and active-low pins high
  assign idle_lvl = mst_pkg::SY_W'(8'hF0);

  mst_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i, module_reset_n_i, module_select_n_i,
              low_power_request_i, rx_los_i, tx_fault_i, other_flag_i}),
    .rst_val_i(idle_lvl),
    .sync_o(s)
  );

  always_comb begin
    nxt_prev = s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= idle_lvl;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [mst_pkg::IRQ_W-1:0] cond_rise;

  always_comb begin
    scl_rise = s[mst_pkg::SY_SCL] & ~prev_ff[mst_pkg::SY_SCL];
    scl_fall = ~s[mst_pkg::SY_SCL] & prev_ff[mst_pkg::SY_SCL];
    bus_start = s[mst_pkg::SY_SCL] & prev_ff[mst_pkg::SY_SCL] & ~s[mst_pkg::SY_SDA] & prev_ff[mst_pkg::SY_SDA];
    bus_stop = s[mst_pkg::SY_SCL] & prev_ff[mst_pkg::SY_SCL] & s[mst_pkg::SY_SDA] & ~prev_ff[mst_pkg::SY_SDA];
    cond_rise = '0;
    cond_rise[mst_pkg::FLG_LOS] = s[mst_pkg::SY_LOS] & ~prev_ff[mst_pkg::SY_LOS];
    cond_rise[mst_pkg::FLG_TXF] = s[mst_pkg::SY_TXF] & ~prev_ff[mst_pkg::SY_TXF];
    cond_rise[mst_pkg::FLG_OTH] = s[mst_pkg::SY_OTH] & ~prev_ff[mst_pkg::SY_OTH];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin qualification
  logic [mst_pkg::RST_CNT_W-1:0] rlow_cnt_ff;
  logic [mst_pkg::RST_CNT_W-1:0] nxt_rlow_cnt;
  logic rst_hold_ff;
  logic nxt_rst_hold;
  logic core_rst;

  always_comb begin
    nxt_rlow_cnt = '0;
    nxt_rst_hold = 1'b0;
    if (!s[mst_pkg::SY_RST]) begin
      nxt_rlow_cnt = rlow_cnt_ff;
      if (rlow_cnt_ff != '1) begin
        nxt_rlow_cnt = rlow_cnt_ff + 1'b1;
      end
      // Only a low level longer than the minimum counts
      nxt_rst_hold = rst_hold_ff | (rlow_cnt_ff > mst_pkg::RST_CNT_W'(mst_pkg::RST_MIN_CYC));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rlow_cnt_ff <= '0;
      rst_hold_ff <= 1'b0;
    end else begin
      rlow_cnt_ff <= nxt_rlow_cnt;
      rst_hold_ff <= nxt_rst_hold;
    end
  end

  // Held module reset restarts the init timer, module flags and 2-wire slave, not the Wishbone side
  assign core_rst = rst_i | rst_hold_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Initialisation timer and data-not-ready
  logic [mst_pkg::INIT_W-1:0] init_cnt_ff;
  logic [mst_pkg::INIT_W-1:0] nxt_init_cnt;
  logic dnr_ff;
  logic nxt_dnr;
  logic ready_set;

  always_comb begin
    nxt_init_cnt = init_cnt_ff;
    nxt_dnr = dnr_ff;
    ready_set = 1'b0;
    if (dnr_ff) begin
      nxt_init_cnt = init_cnt_ff + 1'b1;
      if (init_cnt_ff >= mst_pkg::INIT_W'(INIT_CYCLES - 1)) begin
        nxt_dnr = 1'b0;
        ready_set = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      init_cnt_ff <= '0;
      dnr_ff <= 1'b1;
    end else begin
      init_cnt_ff <= nxt_init_cnt;
      dnr_ff <= nxt_dnr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag units: module flags on the pin, events on Wishbone
  mst_irq_if mod_if ();
  mst_irq_if wb_if ();

  mst_irq u_mod_irq (
    .clk_i(clk_i),
    .rst_i(core_rst),
    .bus(mod_if.core)
  );

  mst_irq u_wb_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(wb_if.core)
  );

  function automatic logic [7:0] rd_byte(input logic [7:0] adr, input logic dnr,
                                         input logic [3:0] flg, input logic [7:0] ctl,
                                         input logic [7:0] msk);
    logic [7:0] b;
    b = '0;
    if (adr == mst_pkg::BYTE_STATUS) begin
      b[mst_pkg::STAT_DNR_BIT] = dnr;
    end else if (adr == mst_pkg::BYTE_FLAGS) begin
      b[3:0] = flg;
    end else if (adr == mst_pkg::BYTE_CTRL) begin
      b = ctl;
    end else if (adr == mst_pkg::BYTE_MASK) begin
      b = msk;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // 2-wire slave
  mst_pkg::mst_i2c_e st_ff;
  mst_pkg::mst_i2c_e nxt_st;
  logic [3:0] bcnt_ff;
  logic [3:0] nxt_bcnt;
  logic [7:0] sr_ff;
  logic [7:0] nxt_sr;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic first_ff;
  logic nxt_first;
  logic nack_ff;
  logic nxt_nack;
  logic oe_ff;
  logic nxt_oe;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] mask2_ff;
  logic [7:0] nxt_mask2;
  logic [7:0] load_b;
  logic [mst_pkg::IRQ_W-1:0] rd_clr;
  logic flag_rd_evt;
  logic ctrl_wr_evt;
  logic active;

  always_comb begin
    // Deselected or not yet ready: stay off the bus
    active = ~s[mst_pkg::SY_SEL] & ~dnr_ff;
    load_b = rd_byte(ptr_ff, dnr_ff, mod_if.flags, ctrl_ff, mask2_ff);
    nxt_st = st_ff;
    nxt_bcnt = bcnt_ff;
    nxt_sr = sr_ff;
    nxt_ptr = ptr_ff;
    nxt_first = first_ff;
    nxt_nack = nack_ff;
    nxt_oe = oe_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask2 = mask2_ff;
    rd_clr = '0;
    flag_rd_evt = 1'b0;
    ctrl_wr_evt = 1'b0;
    if (!active) begin
      nxt_st = mst_pkg::ST_IDLE;
      nxt_oe = 1'b0;
    end else if (bus_start) begin
      nxt_st = mst_pkg::ST_ADDR;
      nxt_bcnt = '0;
      nxt_first = 1'b1;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_st = mst_pkg::ST_IDLE;
      nxt_oe = 1'b0;
    end else if (scl_rise) begin
      case (st_ff)
        mst_pkg::ST_ADDR, mst_pkg::ST_WDATA: begin
          nxt_sr = {sr_ff[6:0], s[mst_pkg::SY_SDA]};
          nxt_bcnt = bcnt_ff + 1'b1;
        end
        mst_pkg::ST_RDATA: begin
          nxt_bcnt = bcnt_ff + 1'b1;
        end
        mst_pkg::ST_RACK: begin
          nxt_nack = s[mst_pkg::SY_SDA];
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_ff)
        mst_pkg::ST_ADDR: begin
          if (bcnt_ff == mst_pkg::BYTE_BITS) begin
            nxt_bcnt = '0;
            if (sr_ff[7:1] == mst_pkg::DEV_ADDR) begin
              nxt_oe = 1'b1;
              nxt_st = mst_pkg::ST_AACK;
            end else begin
              nxt_st = mst_pkg::ST_IDLE;
            end
          end
        end
        mst_pkg::ST_AACK, mst_pkg::ST_RACK: begin
          if ((st_ff == mst_pkg::ST_RACK) && nack_ff) begin
            nxt_oe = 1'b0;
            nxt_st = mst_pkg::ST_IDLE;
          end else if ((st_ff == mst_pkg::ST_RACK) || sr_ff[0]) begin
            nxt_sr = load_b;
            nxt_oe = ~load_b[7];
            nxt_bcnt = '0;
            nxt_st = mst_pkg::ST_RDATA;
            if (ptr_ff == mst_pkg::BYTE_FLAGS) begin
              // Clear only what was shipped; a new set still wins
              rd_clr = load_b[3:0];
              flag_rd_evt = 1'b1;
            end
          end else begin
            nxt_oe = 1'b0;
            nxt_bcnt = '0;
            nxt_st = mst_pkg::ST_WDATA;
          end
        end
        mst_pkg::ST_WDATA: begin
          if (bcnt_ff == mst_pkg::BYTE_BITS) begin
            nxt_bcnt = '0;
            nxt_oe = 1'b1;
            nxt_st = mst_pkg::ST_WACK;
            nxt_first = 1'b0;
            if (first_ff) begin
              nxt_ptr = sr_ff;
            end else begin
              nxt_ptr = ptr_ff + 1'b1;
              if (ptr_ff == mst_pkg::BYTE_CTRL) begin
                nxt_ctrl = sr_ff;
                ctrl_wr_evt = 1'b1;
              end else if (ptr_ff == mst_pkg::BYTE_MASK) begin
                nxt_mask2 = sr_ff;
              end
            end
          end
        end
        mst_pkg::ST_WACK: begin
          nxt_oe = 1'b0;
          nxt_st = mst_pkg::ST_WDATA;
        end
        mst_pkg::ST_RDATA: begin
          if (bcnt_ff == mst_pkg::BYTE_BITS) begin
            nxt_oe = 1'b0;
            nxt_bcnt = '0;
            nxt_ptr = ptr_ff + 1'b1;
            nxt_st = mst_pkg::ST_RACK;
          end else begin
            nxt_sr = {sr_ff[6:0], 1'b0};
            nxt_oe = ~sr_ff[6];
          end
        end
        default: begin
          nxt_st = mst_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      st_ff <= mst_pkg::ST_IDLE;
      bcnt_ff <= '0;
      sr_ff <= '0;
      ptr_ff <= '0;
      first_ff <= 1'b0;
      nack_ff <= 1'b0;
      oe_ff <= 1'b0;
      ctrl_ff <= mst_pkg::CTRL_RST;
      mask2_ff <= mst_pkg::MASK_RST;
    end else begin
      st_ff <= nxt_st;
      bcnt_ff <= nxt_bcnt;
      sr_ff <= nxt_sr;
      ptr_ff <= nxt_ptr;
      first_ff <= nxt_first;
      nack_ff <= nxt_nack;
      oe_ff <= nxt_oe;
      ctrl_ff <= nxt_ctrl;
      mask2_ff <= nxt_mask2;
    end
  end

  always_comb begin
    mod_if.set = cond_rise;
    mod_if.set[mst_pkg::FLG_RDY] = ready_set;
    mod_if.clr = rd_clr;
    mod_if.mask = mask2_ff[mst_pkg::IRQ_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, write at the ack edge
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [3:0] wb_mask_ff;
  logic [3:0] nxt_wb_mask;
  logic wb_wr;

  always_comb begin
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
    nxt_wb_mask = wb_mask_ff;
    nxt_dat = '0;
    wb_if.clr = '0;
    if (wb_adr_i == mst_pkg::WB_STAT) begin
      nxt_dat[3:0] = wb_if.flags;
      if (wb_wr) begin
        wb_if.clr = wb_dat_i[3:0];
      end
    end else if (wb_adr_i == mst_pkg::WB_MASK) begin
      nxt_dat[3:0] = wb_mask_ff;
      if (wb_wr) begin
        nxt_wb_mask = wb_dat_i[3:0];
      end
    end else if (wb_adr_i == mst_pkg::WB_STATE) begin
      nxt_dat[11:0] = {~s[mst_pkg::SY_SEL], low_power_o, dnr_ff, rst_hold_ff, mask2_ff[3:0], mod_if.flags};
    end
    wb_if.set = '0;
    wb_if.set[mst_pkg::EVT_RDY] = ready_set;
    wb_if.set[mst_pkg::EVT_RST] = rst_hold_ff & s[mst_pkg::SY_RST];
    wb_if.set[mst_pkg::EVT_FRD] = flag_rd_evt;
    wb_if.set[mst_pkg::EVT_CWR] = ctrl_wr_evt;
    wb_if.mask = wb_mask_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
      wb_mask_ff <= '1;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      wb_mask_ff <= nxt_wb_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic int_n_ff;
  logic irq_ff;
  logic lp_ff;
  logic pres_n_ff;
  logic sda_lvl_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_n_ff <= 1'b1;
      irq_ff <= 1'b0;
      lp_ff <= 1'b0;
      pres_n_ff <= 1'b0;
      sda_lvl_ff <= 1'b0;
    end else begin
      int_n_ff <= ~mod_if.irq;
      irq_ff <= wb_if.irq;
      lp_ff <= s[mst_pkg::SY_LPR] | ctrl_ff[mst_pkg::CTRL_PDOWN_BIT];
      pres_n_ff <= 1'b0;
      sda_lvl_ff <= 1'b0;
    end
  end

  assign interrupt_n_o = int_n_ff;
  assign wb_irq_o = irq_ff;
  assign low_power_o = lp_ff;
  assign module_present_n_o = pres_n_ff;
  assign sda_o = sda_lvl_ff;
  assign sda_oe_o = oe_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule

// ### bench/mst_sideband_chk.sv
// Purpose: Port-level assertions for mst_sideband
// Assumes: single clock domain, rst_i synchronous
// Notes: counters stand in for the long init and reset spans
`timescale 1ns/1ps
module mst_sideband_chk #(
  parameter int unsigned INIT_CYCLES = 100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic interrupt_n_o,
  input wire logic low_power_o
);
  logic [31:0] up_ff;
  logic [31:0] nxt_up;
  logic [9:0] lo_ff;
  logic [9:0] nxt_lo;
  // Both saturate so a long run never wraps into a false window
  always_comb begin
    nxt_up = (&up_ff) ? up_ff : up_ff + 32'h1;
    nxt_lo = module_reset_n_i ? 10'h0 : ((&lo_ff) ? lo_ff : lo_ff + 10'h1);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_ff <= 32'h0;
      lo_ff <= 10'h0;
    end else begin
      up_ff <= nxt_up;
      lo_ff <= nxt_lo;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req; $rose(wb_cyc_i && wb_stb_i); endsequence
  sequence lp_held; low_power_request_i [*6]; endsequence
  sequence desel_held; module_select_n_i [*5]; endsequence
  wb_ack_a: assert property (wb_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  sda_drain_a: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  desel_quiet_a: assert property (desel_held |-> !sda_oe_o)
    else $error("answer while deselected");
  low_power_a: assert property (lp_held |-> low_power_o)
    else $error("low power not entered");
  reset_hold_a: assert property (lo_ff > 10'h10E |-> interrupt_n_o && !sda_oe_o)
    else $error("long reset pulse not taken");
  init_silent_a: assert property (up_ff < INIT_CYCLES |-> !sda_oe_o)
    else $error("answer before init done");
  init_done_a: assert property (up_ff == INIT_CYCLES + 16 |-> !interrupt_n_o)
    else $error("interrupt missing after init");
endmodule
bind mst_sideband mst_sideband_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .module_reset_n_i, .module_select_n_i, .low_power_request_i,
  .sda_o, .sda_oe_o, .interrupt_n_o, .low_power_o);

// ### bench/mst_host_mdl.sv
// Purpose: Host 2-wire master for the sideband block
// Assumes: SCL period 160 ns, SDA pulled up on the board
// Notes: SCL stands high between frames
`timescale 1ns/1ps
module mst_host_mdl (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic start();
    sda_o = 1'h1;
    #40 scl_o = 1'h1;
    #40 sda_o = 1'h0;
    #40 scl_o = 1'h0;
    #40;
  endtask
  task automatic stop();
    sda_o = 1'h0;
    #40 scl_o = 1'h1;
    #40 sda_o = 1'h1;
    #40;
  endtask
  task automatic bit_w(input logic b);
    sda_o = b;
    #40 scl_o = 1'h1;
    #80 scl_o = 1'h0;
    #40;
  endtask
  // Released line reads the pull-up unless the module holds it low
  task automatic bit_r(output logic b);
    sda_o = 1'h1;
    #40 scl_o = 1'h1;
    #40 b = sda_i;
    #40 scl_o = 1'h0;
    #40;
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_w(d[i]);
    bit_r(a);
    ack = ~a;
  endtask
  task automatic byte_r(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_r(d[i]);
    bit_w(1'h1);
  endtask
  // The 3 ns lead shifts each frame against the system clock
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    #3;
    start();
    byte_w({mst_pkg::DEV_ADDR, 1'h0}, a0);
    byte_w(p, a1);
    byte_w(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    #3;
    start();
    byte_w({mst_pkg::DEV_ADDR, 1'h0}, a0);
    byte_w(p, a1);
    start();
    byte_w({mst_pkg::DEV_ADDR, 1'h1}, a2);
    byte_r(d);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

// ### bench/mst_sideband_bench.sv
// Purpose: Self-checking bench for mst_sideband
// Assumes: shortened init count, host model on the 2-wire pins
// Notes: fixed waits follow the latencies of the hand-over
`timescale 1ns/1ps
module mst_sideband_bench;
  localparam int unsigned INIT = 2000;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic module_reset_n_i, module_select_n_i, low_power_request_i, rx_los_i, tx_fault_i, other_flag_i;
  logic scl_i, sda_i, host_sda, sda_o, sda_oe_o, interrupt_n_o, module_present_n_o, low_power_o, a;
  logic [7:0] b;
  int errors, tests_run;
  assign sda_i = host_sda & ~sda_oe_o;
  mst_sideband #(.INIT_CYCLES(INIT)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_irq_o, .module_reset_n_i, .module_select_n_i,
    .low_power_request_i, .rx_los_i, .tx_fault_i, .other_flag_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .interrupt_n_o, .module_present_n_o, .low_power_o);
  mst_host_mdl host (.sda_i(sda_i), .scl_o(scl_i), .sda_o(host_sda));
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_sel_i <= 4'hF;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    chk("wb ack", 32'h1, wb_ack_o);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    wb(1'h0, mst_pkg::WB_STATE, 32'h0, q);
    chk("state", 32'h200, q & 32'h7FF);
    wb(1'h0, mst_pkg::WB_MASK, 32'h0, q);
    chk("wb mask", 32'hF, q);
    wb(1'h1, 8'h0C, 32'hF, q);
    wb(1'h0, 8'h0C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("present", 32'h0, module_present_n_o);
    host.wr(mst_pkg::BYTE_MASK, 8'h01, a);
    chk("early ack", 32'h0, a);
  endtask
  task automatic t_init();
    cyc(INIT + 20);
    chk("ready int", 32'h0, interrupt_n_o);
    host.rd(mst_pkg::BYTE_STATUS, b, a);
    chk("status ack", 32'h1, a);
    chk("not ready", 32'h0, b[0]);
    host.rd(mst_pkg::BYTE_FLAGS, b, a);
    chk("ready flag", 32'h8, b);
    cyc(8);
    chk("int off", 32'h1, interrupt_n_o);
  endtask
  task automatic t_flags();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {other_flag_i, tx_fault_i, rx_los_i} <= 3'h1 << i;
      cyc(8);
      chk("flag int", 32'h0, interrupt_n_o);
      host.rd(mst_pkg::BYTE_FLAGS, b, a);
      chk("flag byte", 32'h1 << i, b);
      cyc(8);
      chk("flag int off", 32'h1, interrupt_n_o);
    end
    @(posedge clk_i);
    {other_flag_i, tx_fault_i, rx_los_i} <= 3'h0;
    cyc(4);
    {other_flag_i, tx_fault_i, rx_los_i} <= 3'h7;
    cyc(8);
    host.wr(mst_pkg::BYTE_MASK, 8'h01, a);
    cyc(8);
    chk("part mask", 32'h0, interrupt_n_o);
    host.wr(mst_pkg::BYTE_MASK, 8'h07, a);
    cyc(8);
    chk("full mask", 32'h1, interrupt_n_o);
    host.wr(mst_pkg::BYTE_MASK, 8'h00, a);
    cyc(8);
    chk("unmask", 32'h0, interrupt_n_o);
    host.rd(mst_pkg::BYTE_FLAGS, b, a);
    chk("all flags", 32'h7, b);
    cyc(8);
    chk("all clear", 32'h1, interrupt_n_o);
  endtask
  task automatic t_sel();
    @(posedge clk_i);
    module_select_n_i <= 1'h1;
    cyc(8);
    host.wr(mst_pkg::BYTE_MASK, 8'h00, a);
    chk("desel ack", 32'h0, a);
    @(posedge clk_i);
    module_select_n_i <= 1'h0;
    cyc(8);
    host.wr(mst_pkg::BYTE_MASK, 8'h00, a);
    chk("sel ack", 32'h1, a);
  endtask
  task automatic t_power();
    @(posedge clk_i);
    low_power_request_i <= 1'h1;
    cyc(8);
    chk("lp pin", 32'h1, low_power_o);
    low_power_request_i <= 1'h0;
    cyc(8);
    chk("lp pin off", 32'h0, low_power_o);
    host.wr(mst_pkg::BYTE_CTRL, 8'h01, a);
    cyc(8);
    chk("pdown", 32'h1, low_power_o);
    host.wr(mst_pkg::BYTE_CTRL, 8'h00, a);
    cyc(8);
    chk("pdown off", 32'h0, low_power_o);
  endtask
  task automatic t_wbirq();
    chk("irq masked", 32'h0, wb_irq_o);
    wb(1'h1, mst_pkg::WB_MASK, 32'h0, q);
    cyc(3);
    chk("irq", 32'h1, wb_irq_o);
    wb(1'h0, mst_pkg::WB_STAT, 32'h0, q);
    chk("events", 32'hD, q);
    wb(1'h1, mst_pkg::WB_STAT, 32'hF, q);
    cyc(3);
    chk("irq off", 32'h0, wb_irq_o);
  endtask
  task automatic t_mreset();
    @(posedge clk_i);
    module_reset_n_i <= 1'h0;
    cyc(100);
    module_reset_n_i <= 1'h1;
    cyc(8);
    wb(1'h0, mst_pkg::WB_STATE, 32'h0, q);
    chk("short pulse", 32'h0, q[9:8]);
    @(posedge clk_i);
    module_reset_n_i <= 1'h0;
    cyc(300);
    wb(1'h0, mst_pkg::WB_STATE, 32'h0, q);
    chk("reset held", 32'h3, q[9:8]);
    @(posedge clk_i);
    module_reset_n_i <= 1'h1;
    cyc(INIT + 20);
    chk("reinit int", 32'h0, interrupt_n_o);
    wb(1'h0, mst_pkg::WB_STAT, 32'h0, q);
    chk("release event", 32'h3, q);
  endtask
  ////////////////////////////////////////
  // Span covers two inits and fourteen 2-wire frames
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    {module_reset_n_i, module_select_n_i, low_power_request_i} = 3'h4;
    {rx_los_i, tx_fault_i, other_flag_i} = 3'h0;
    errors = 0;
    tests_run = 0;
    cyc(3);
    rst_i <= 1'h0;
    t_reset();
    t_init();
    t_flags();
    t_sel();
    t_power();
    t_wbirq();
    t_mreset();
    finish_test();
  end
endmodule
